// File: inc/prot_pkg.sv
//////////////////////////////////////////////////////////////////////////////
// Operation
// RL1 - thermistor guard register at 0x0B, read/write byte, resets to 0x00
// RL2 - timer select 0, led-controlled flash: reset safety timer after 30ms low
// RL3 - timer select 1: reset safety timer at once when led enable drops
// RL4 - thermistor guard bits 6..4 reserved, read zero
// RL5 - thermistor guard bit 3 enables finger-burn protection, default off
// RL6 - thermistor threshold code 000..111 selects 200mV..550mV in 50mV steps
// RL7 - transmit-blank register at 0x0C, read/write byte, resets to 0xC0
// RL8 - transmit-blank bit 7 enables blank input, otherwise input ignored
// RL9 - transmit-blank bit 6 selects blank input level: 0 low, 1 high
// RL10 - current limit code bits 5..2 selects 50mA..800mA in 50mA steps
// RL11 - blank reset timer code selects 10, 20, 40 or 80us
// RL12 - low-battery register at 0x0D, read/write byte, resets to 0x00
// RL13 - low-battery bit 7 enables flash current reduction at low battery
// RL14 - low-battery threshold 2.400V up by ~33mV, top two codes 3.400V
// RL15 - hysteresis 00 100mV, 01 200mV, 10 reserved, 11 no hysteresis
// RL16 - flash codes 101, 110, 111 gate regulators with led enable input
// RL17 - blank event sets latched status flag, cleared by status read
// RL18 - reserved bits ignore writes and read back zero
// RL19 - written value takes effect only after byte received and acknowledged
//////////////////////////////////////////////////////////////////////////////
package prot_pkg;
	localparam int CLK_PERIOD_NS = 40;
	// register map
	localparam logic [7:0] TEMP_GUARD_OFFSET = 8'h0b;
	localparam logic [7:0] BLANK_CTRL_OFFSET = 8'h0c;
	localparam logic [7:0] LOW_BATT_OFFSET = 8'h0d;
	localparam logic [7:0] STATUS_OFFSET = 8'h17;
	localparam logic [7:0] TEMP_GUARD_RESET = 8'h00;
	localparam logic [7:0] BLANK_CTRL_RESET = 8'hc0;
	localparam logic [7:0] LOW_BATT_RESET = 8'h00;
	localparam logic [7:0] TEMP_GUARD_MASK = 8'h8f;
	localparam logic [7:0] FULL_MASK = 8'hff;
	localparam logic [7:0] UNMAPPED_DATA = 8'h00;
	// field positions
	localparam int TG_TIMER_SEL_BIT = 7;
	localparam int TG_ENABLE_BIT = 3;
	localparam int TG_THRESH_LSB = 0;
	localparam int BC_ENABLE_BIT = 7;
	localparam int BC_POL_BIT = 6;
	localparam int BC_ILIM_LSB = 2;
	localparam int BC_TMR_LSB = 0;
	localparam int LB_ENABLE_BIT = 7;
	localparam int LB_THRESH_LSB = 2;
	localparam int LB_HYST_LSB = 0;
	localparam int STATUS_BLANK_BIT = 6;
	// timing
	localparam int SAFETY_LOW_MS = 30;
	localparam int SAFETY_LOW_CYCLES = (SAFETY_LOW_MS * 1000000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int BLANK_BASE_US = 10;
	localparam int BLANK_BASE_CYCLES = (BLANK_BASE_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int TIMER_WIDTH = 20;
	// analog settings
	localparam int NTC_BASE_MV = 200;
	localparam int NTC_STEP_MV = 50;
	localparam int ILIM_BASE_MA = 50;
	localparam int ILIM_STEP_MA = 50;
	localparam int LB_BASE_MV = 2400;
	localparam int LB_THREE_STEP_MV = 100;
	localparam logic [4:0] LB_TOP_CODE = 5'h1e;
	localparam logic [7:0] HYS_LOW_MV = 8'h64;
	localparam logic [7:0] HYS_HIGH_MV = 8'hc8;
	localparam logic [7:0] HYS_NONE_MV = 8'h00;
	// arbitrary neutral bus address
	localparam logic [6:0] DEFAULT_SLAVE_ADDR = 7'h2a;

	function automatic logic [9:0] ntc_mv(input logic [2:0] code);
		return 10'(NTC_BASE_MV + NTC_STEP_MV * int'(code));
	endfunction : ntc_mv

	function automatic logic [9:0] ilim_ma(input logic [3:0] code);
		return 10'(ILIM_BASE_MA + ILIM_STEP_MA * int'(code));
	endfunction : ilim_ma

	function automatic logic [11:0] lb_mv(input logic [4:0] code);
		logic [4:0] c;
		c = (code > LB_TOP_CODE) ? LB_TOP_CODE : code;
		return 12'(LB_BASE_MV + (LB_THREE_STEP_MV * int'(c)) / 3);
	endfunction : lb_mv

	function automatic logic [TIMER_WIDTH-1:0] blank_cycles(input logic [1:0] code);
		return TIMER_WIDTH'(BLANK_BASE_CYCLES << code);
	endfunction : blank_cycles
endpackage : prot_pkg

// File: inc/prot_reg_if.sv
`timescale 1ns/1ps
interface prot_reg_if;
	logic wr_en;
	logic rd_en;
	logic [7:0] addr;
	logic [7:0] wdata;
	logic [7:0] rdata;
	logic blank_event;
	logic [7:0] temp_guard;
	logic [7:0] blank_ctrl;
	logic [7:0] low_batt;
	modport master (output wr_en, rd_en, addr, wdata, blank_event, input rdata, temp_guard, blank_ctrl, low_batt);
	modport regs (input wr_en, rd_en, addr, wdata, blank_event, output rdata, temp_guard, blank_ctrl, low_batt);
endinterface : prot_reg_if

// File: logic/prot_hold_timer.sv
`timescale 1ns/1ps
module prot_hold_timer #(
	parameter int WIDTH = 20
) (
	// clock and reset
	input wire logic clock,
	input wire logic reset_n,
	// control
	input wire logic run,
	input wire logic [WIDTH-1:0] limit,
	// result
	output logic expired
);
	logic [WIDTH-1:0] count_ff;
	logic expired_ff;
	// saturates so that one long run gives a single pulse
	wire at_limit = (count_ff == limit);
	wire [WIDTH-1:0] nxt_count = !run ? '0 : at_limit ? count_ff : count_ff + 1'b1;
	wire nxt_expired = run && (count_ff == limit - 1'b1);

	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			count_ff <= '0;
			expired_ff <= 1'b0;
		end else begin
			count_ff <= nxt_count;
			expired_ff <= nxt_expired;
		end
	end

	assign expired = expired_ff;
endmodule : prot_hold_timer

// File: logic/prot_regs.sv
`timescale 1ns/1ps
module prot_regs (
	// clock and reset
	input wire logic clock,
	input wire logic reset_n,
	// access from the serial slave
	prot_reg_if.regs bus
);
	logic [7:0] temp_guard_ff;
	logic [7:0] blank_ctrl_ff;
	logic [7:0] low_batt_ff;
	logic blank_flag_ff;
	wire wr_tg = bus.wr_en && (bus.addr == prot_pkg::TEMP_GUARD_OFFSET);
	wire wr_bc = bus.wr_en && (bus.addr == prot_pkg::BLANK_CTRL_OFFSET);
	wire wr_lb = bus.wr_en && (bus.addr == prot_pkg::LOW_BATT_OFFSET);
	wire rd_status = bus.rd_en && (bus.addr == prot_pkg::STATUS_OFFSET);
	// RL17 set beats clear
	wire nxt_blank_flag = bus.blank_event | (blank_flag_ff & ~rd_status);
	wire [7:0] status_byte = 8'(blank_flag_ff) << prot_pkg::STATUS_BLANK_BIT;

	// RL1 RL7 RL12 reset values
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			temp_guard_ff <= prot_pkg::TEMP_GUARD_RESET;
			blank_ctrl_ff <= prot_pkg::BLANK_CTRL_RESET;
			low_batt_ff <= prot_pkg::LOW_BATT_RESET;
			blank_flag_ff <= 1'b0;
		end else begin
			// RL4 RL18 reserved masked
			if (wr_tg) temp_guard_ff <= bus.wdata & prot_pkg::TEMP_GUARD_MASK;
			if (wr_bc) blank_ctrl_ff <= bus.wdata & prot_pkg::FULL_MASK;
			if (wr_lb) low_batt_ff <= bus.wdata & prot_pkg::FULL_MASK;
			blank_flag_ff <= nxt_blank_flag;
		end
	end

	assign bus.rdata = (bus.addr == prot_pkg::TEMP_GUARD_OFFSET) ? temp_guard_ff :
		(bus.addr == prot_pkg::BLANK_CTRL_OFFSET) ? blank_ctrl_ff :
		(bus.addr == prot_pkg::LOW_BATT_OFFSET) ? low_batt_ff :
		(bus.addr == prot_pkg::STATUS_OFFSET) ? status_byte : prot_pkg::UNMAPPED_DATA;
	assign bus.temp_guard = temp_guard_ff;
	assign bus.blank_ctrl = blank_ctrl_ff;
	assign bus.low_batt = low_batt_ff;
endmodule : prot_regs

// File: logic/prot_top.sv
`timescale 1ns/1ps
module prot_top #(
	parameter int SAFETY_LOW_CYCLES = prot_pkg::SAFETY_LOW_CYCLES,
	parameter logic [6:0] SLAVE_ADDR = prot_pkg::DEFAULT_SLAVE_ADDR
) (
	// clock and reset
	input wire logic clock,
	input wire logic reset_n,
	// serial bus
	input wire logic scl_in,
	input wire logic sda_in,
	output logic sda_out,
	output logic sda_oe,
	// flash control
	input wire logic led_enable_input,
	input wire logic [2:0] flash_enable_field,
	output logic first_flash_regulator,
	output logic second_flash_regulator,
	output logic safety_timer_reset,
	// thermistor guard
	output logic thermistor_guard_enable,
	output logic [9:0] thermistor_trip_mv,
	// transmit blank
	input wire logic transmit_blank_input,
	output logic blank_limit_active,
	output logic [9:0] blank_current_limit_ma,
	// low battery
	output logic low_battery_enable,
	output logic [11:0] low_battery_threshold_mv,
	output logic [7:0] low_battery_hysteresis_mv,
	output logic low_battery_hysteresis_off
);
	//////////////////////////////////////////////////////////////////////////
	// serial slave
	typedef enum logic [3:0] {
		st_idle, st_addr, st_addr_ack, st_reg, st_reg_ack,
		st_wdata, st_wdata_ack, st_tx, st_mack
	} prot_state_type;

	prot_reg_if rif ();

	prot_state_type state_ff;
	prot_state_type nxt_state;
	logic [3:0] cnt_ff;
	logic [3:0] nxt_cnt;
	logic [7:0] shift_ff;
	logic [7:0] nxt_shift;
	logic [7:0] tx_ff;
	logic [7:0] nxt_tx;
	logic [7:0] ptr_ff;
	logic [7:0] nxt_ptr;
	logic rw_ff;
	logic nxt_rw;
	logic mack_ff;
	logic nxt_mack;
	logic sda_oe_ff;
	logic nxt_sda_oe;
	logic scl_prev_ff;
	logic sda_prev_ff;
	logic wr_pulse;
	logic rd_pulse;

	// bus pins are taken as synchronous; one stage of history finds edges
	wire scl_rise = scl_in & ~scl_prev_ff;
	wire scl_fall = ~scl_in & scl_prev_ff;
	wire bus_start = scl_in & scl_prev_ff & sda_prev_ff & ~sda_in;
	wire bus_stop = scl_in & scl_prev_ff & ~sda_prev_ff & sda_in;
	wire byte_full = (cnt_ff == 4'h8);
	wire addr_match = (shift_ff[7:1] == SLAVE_ADDR);
	wire receiving = (state_ff == st_addr) || (state_ff == st_reg) || (state_ff == st_wdata);

	always_comb begin
		nxt_state = state_ff;
		nxt_cnt = cnt_ff;
		nxt_shift = shift_ff;
		nxt_tx = tx_ff;
		nxt_ptr = ptr_ff;
		nxt_rw = rw_ff;
		nxt_mack = mack_ff;
		nxt_sda_oe = sda_oe_ff;
		wr_pulse = 1'b0;
		rd_pulse = 1'b0;
		if (bus_stop) begin
			nxt_state = st_idle;
			nxt_sda_oe = 1'b0;
		end else if (bus_start) begin
			nxt_state = st_addr;
			nxt_cnt = 4'h0;
			nxt_sda_oe = 1'b0;
		end else if (scl_rise) begin
			if (receiving && !byte_full) begin
				nxt_shift = {shift_ff[6:0], sda_in};
				nxt_cnt = cnt_ff + 4'h1;
			end
			if (state_ff == st_mack) begin
				nxt_mack = ~sda_in;
			end
		end else if (scl_fall) begin
			case (state_ff)
				st_addr: begin
					if (byte_full) begin
						nxt_state = addr_match ? st_addr_ack : st_idle;
						nxt_sda_oe = addr_match;
						nxt_rw = shift_ff[0];
					end
				end
				st_reg: begin
					if (byte_full) begin
						nxt_state = st_reg_ack;
						nxt_sda_oe = 1'b1;
						nxt_ptr = shift_ff;
					end
				end
				st_wdata: begin
					if (byte_full) begin
						nxt_state = st_wdata_ack;
						nxt_sda_oe = 1'b1;
					end
				end
				st_reg_ack: begin
					nxt_state = st_wdata;
					nxt_cnt = 4'h0;
					nxt_sda_oe = 1'b0;
				end
				st_wdata_ack: begin
					// RL19 commit after ack clock
					wr_pulse = 1'b1;
					nxt_ptr = ptr_ff + 8'h01;
					nxt_state = st_wdata;
					nxt_cnt = 4'h0;
					nxt_sda_oe = 1'b0;
				end
				st_addr_ack: begin
					if (rw_ff) begin
						rd_pulse = 1'b1;
						nxt_tx = rif.rdata;
						nxt_ptr = ptr_ff + 8'h01;
						nxt_sda_oe = ~rif.rdata[7];
						nxt_cnt = 4'h1;
						nxt_state = st_tx;
					end else begin
						nxt_sda_oe = 1'b0;
						nxt_cnt = 4'h0;
						nxt_state = st_reg;
					end
				end
				st_tx: begin
					if (!byte_full) begin
						nxt_sda_oe = ~tx_ff[6];
						nxt_tx = {tx_ff[6:0], 1'b0};
						nxt_cnt = cnt_ff + 4'h1;
					end else begin
						nxt_sda_oe = 1'b0;
						nxt_state = st_mack;
					end
				end
				st_mack: begin
					if (mack_ff) begin
						rd_pulse = 1'b1;
						nxt_tx = rif.rdata;
						nxt_ptr = ptr_ff + 8'h01;
						nxt_sda_oe = ~rif.rdata[7];
						nxt_cnt = 4'h1;
						nxt_state = st_tx;
					end else begin
						nxt_state = st_idle;
					end
				end
				default: begin
					nxt_sda_oe = 1'b0;
				end
			endcase
		end
	end

	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			state_ff <= st_idle;
			cnt_ff <= 4'h0;
			shift_ff <= 8'h00;
			tx_ff <= 8'h00;
			ptr_ff <= 8'h00;
			rw_ff <= 1'b0;
			mack_ff <= 1'b0;
			sda_oe_ff <= 1'b0;
			scl_prev_ff <= 1'b1;
			sda_prev_ff <= 1'b1;
		end else begin
			state_ff <= nxt_state;
			cnt_ff <= nxt_cnt;
			shift_ff <= nxt_shift;
			tx_ff <= nxt_tx;
			ptr_ff <= nxt_ptr;
			rw_ff <= nxt_rw;
			mack_ff <= nxt_mack;
			sda_oe_ff <= nxt_sda_oe;
			scl_prev_ff <= scl_in;
			sda_prev_ff <= sda_in;
		end
	end

	assign rif.wr_en = wr_pulse;
	assign rif.rd_en = rd_pulse;
	assign rif.addr = ptr_ff;
	assign rif.wdata = shift_ff;

	prot_regs u_regs (
		.clock(clock),
		.reset_n(reset_n),
		.bus(rif.regs)
	);

	//////////////////////////////////////////////////////////////////////////
	// field decode
	wire timer_immediate = rif.temp_guard[prot_pkg::TG_TIMER_SEL_BIT];
	// RL5 guard enable
	wire nxt_guard_en = rif.temp_guard[prot_pkg::TG_ENABLE_BIT];
	// RL6 trip level
	wire [9:0] nxt_trip_mv = prot_pkg::ntc_mv(rif.temp_guard[prot_pkg::TG_THRESH_LSB +: 3]);
	// RL8 blank enable
	wire blank_en = rif.blank_ctrl[prot_pkg::BC_ENABLE_BIT];
	wire blank_pol = rif.blank_ctrl[prot_pkg::BC_POL_BIT];
	// RL10 input current limit
	wire [9:0] nxt_ilim_ma = prot_pkg::ilim_ma(rif.blank_ctrl[prot_pkg::BC_ILIM_LSB +: 4]);
	// RL11 blank reset time
	wire [prot_pkg::TIMER_WIDTH-1:0] blank_limit = prot_pkg::blank_cycles(rif.blank_ctrl[prot_pkg::BC_TMR_LSB +: 2]);
	// RL13 low-battery enable
	wire nxt_lb_on = rif.low_batt[prot_pkg::LB_ENABLE_BIT];
	// RL14 threshold with top clamp
	wire [11:0] nxt_lb_mv = prot_pkg::lb_mv(rif.low_batt[prot_pkg::LB_THRESH_LSB +: 5]);
	wire [1:0] hys_code = rif.low_batt[prot_pkg::LB_HYST_LSB +: 2];
	// RL15 hysteresis, reserved code gives none
	wire [7:0] nxt_hys_mv = (hys_code == 2'b00) ? prot_pkg::HYS_LOW_MV :
		(hys_code == 2'b01) ? prot_pkg::HYS_HIGH_MV : prot_pkg::HYS_NONE_MV;
	wire nxt_hys_off = (hys_code == 2'b11);

	//////////////////////////////////////////////////////////////////////////
	// flash gating and safety timer reset
	logic led_prev_ff;
	logic safety_low_expired;
	wire led_fall = led_prev_ff & ~led_enable_input;
	wire led_gate = ~flash_enable_field[2] | led_enable_input;
	wire led_mode = flash_enable_field[2] & (flash_enable_field[1:0] != 2'b00);
	// RL16 led enable gating
	wire nxt_first = flash_enable_field[0] & led_gate;
	wire nxt_second = flash_enable_field[1] & led_gate;
	// RL2 long low only in led mode
	wire long_low = ~timer_immediate & led_mode;
	// RL2 RL3 reset source
	wire nxt_safety_reset = long_low ? safety_low_expired : led_fall;

	prot_hold_timer #(
		.WIDTH(prot_pkg::TIMER_WIDTH)
	) u_safety_low (
		.clock(clock),
		.reset_n(reset_n),
		.run(long_low & ~led_enable_input),
		.limit(prot_pkg::TIMER_WIDTH'(SAFETY_LOW_CYCLES)),
		.expired(safety_low_expired)
	);

	//////////////////////////////////////////////////////////////////////////
	// transmit blank
	logic blank_prev_ff;
	logic blank_hold_ff;
	logic blank_hold_expired;
	// RL8 RL9 qualified input
	wire blank_now = blank_en & (blank_pol ? transmit_blank_input : ~transmit_blank_input);
	// RL17 event on assertion
	assign rif.blank_event = blank_now & ~blank_prev_ff;
	// limit stays on for the reset time after the input lets go
	wire nxt_blank_hold = blank_now | (blank_hold_ff & ~blank_hold_expired);

	// RL11 hold after release
	prot_hold_timer #(
		.WIDTH(prot_pkg::TIMER_WIDTH)
	) u_blank_hold (
		.clock(clock),
		.reset_n(reset_n),
		.run(blank_hold_ff & ~blank_now),
		.limit(blank_limit),
		.expired(blank_hold_expired)
	);

	//////////////////////////////////////////////////////////////////////////
	// output registers
	logic first_ff;
	logic second_ff;
	logic safety_reset_ff;
	logic guard_en_ff;
	logic [9:0] trip_mv_ff;
	logic [9:0] ilim_ma_ff;
	logic lb_on_ff;
	logic [11:0] lb_mv_ff;
	logic [7:0] hys_mv_ff;
	logic hys_off_ff;

	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			led_prev_ff <= 1'b0;
			blank_prev_ff <= 1'b0;
			blank_hold_ff <= 1'b0;
			first_ff <= 1'b0;
			second_ff <= 1'b0;
			safety_reset_ff <= 1'b0;
			guard_en_ff <= 1'b0;
			trip_mv_ff <= 10'h0c8;
			ilim_ma_ff <= 10'h032;
			lb_on_ff <= 1'b0;
			lb_mv_ff <= 12'h960;
			hys_mv_ff <= 8'h64;
			hys_off_ff <= 1'b0;
		end else begin
			led_prev_ff <= led_enable_input;
			blank_prev_ff <= blank_now;
			blank_hold_ff <= nxt_blank_hold;
			first_ff <= nxt_first;
			second_ff <= nxt_second;
			safety_reset_ff <= nxt_safety_reset;
			guard_en_ff <= nxt_guard_en;
			trip_mv_ff <= nxt_trip_mv;
			ilim_ma_ff <= nxt_ilim_ma;
			lb_on_ff <= nxt_lb_on;
			lb_mv_ff <= nxt_lb_mv;
			hys_mv_ff <= nxt_hys_mv;
			hys_off_ff <= nxt_hys_off;
		end
	end

	assign sda_out = 1'b0;
	assign sda_oe = sda_oe_ff;
	assign first_flash_regulator = first_ff;
	assign second_flash_regulator = second_ff;
	assign safety_timer_reset = safety_reset_ff;
	assign thermistor_guard_enable = guard_en_ff;
	assign thermistor_trip_mv = trip_mv_ff;
	assign blank_limit_active = blank_hold_ff;
	assign blank_current_limit_ma = ilim_ma_ff;
	assign low_battery_enable = lb_on_ff;
	assign low_battery_threshold_mv = lb_mv_ff;
	assign low_battery_hysteresis_mv = hys_mv_ff;
	assign low_battery_hysteresis_off = hys_off_ff;
endmodule : prot_top

// File: verif/prot_checker.sv
`timescale 1ns/1ps
module prot_checker #(
	parameter int SAFETY_LOW_CYCLES = 50
) (
	// clock and reset
	input wire logic clock,
	input wire logic reset_n,
	// serial bus
	input wire logic scl_in,
	input wire logic sda_in,
	input wire logic sda_out,
	input wire logic sda_oe,
	// flash control
	input wire logic led_enable_input,
	input wire logic [2:0] flash_enable_field,
	input wire logic first_flash_regulator,
	input wire logic second_flash_regulator,
	input wire logic safety_timer_reset,
	// decoded settings and transmit blank
	input wire logic thermistor_guard_enable,
	input wire logic [9:0] thermistor_trip_mv,
	input wire logic transmit_blank_input,
	input wire logic blank_limit_active,
	input wire logic [9:0] blank_current_limit_ma,
	input wire logic low_battery_enable,
	input wire logic [11:0] low_battery_threshold_mv,
	input wire logic [7:0] low_battery_hysteresis_mv,
	input wire logic low_battery_hysteresis_off
);
	default clocking @(posedge clock);
	endclocking
	default disable iff (!reset_n);
	////////////////////////////////////////
	chk_trip_grid: assert property (thermistor_trip_mv inside {[200:550]} && thermistor_trip_mv % 50 == 0)
		else $error("trip level off grid");
	chk_ilim_grid: assert property (blank_current_limit_ma inside {[50:800]} && blank_current_limit_ma % 50 == 0)
		else $error("current limit off grid");
	chk_lb_range: assert property (low_battery_threshold_mv inside {[2400:3400]})
		else $error("threshold out of range");
	chk_hys_code: assert property (low_battery_hysteresis_mv inside {8'h64, 8'hc8, 8'h00} &&
		(!low_battery_hysteresis_off || low_battery_hysteresis_mv == 8'h00)) else $error("bad hysteresis");
	chk_gate_led: assert property (flash_enable_field[2] && !led_enable_input |=>
		!first_flash_regulator && !second_flash_regulator) else $error("regulator not gated");
	chk_fixed_on: assert property (flash_enable_field == 3'b011 |=>
		first_flash_regulator && second_flash_regulator) else $error("regulators not on");
	chk_quick_reset: assert property ($fell(led_enable_input) && !flash_enable_field[2] |->
		##[1:4] safety_timer_reset) else $error("no prompt timer reset");
	chk_pulse_once: assert property (safety_timer_reset |=> !safety_timer_reset)
		else $error("reset pulse too long");
	// settings may only move while scl is low, i.e. after a complete acked byte
	chk_update_when: assert property ($changed(thermistor_trip_mv) || $changed(blank_current_limit_ma) ||
		$changed(low_battery_threshold_mv) |-> !scl_in) else $error("setting changed mid byte");
	cover property (safety_timer_reset);
	cover property ($rose(blank_limit_active));
	cover property ($rose(sda_oe));
endmodule : prot_checker

bind prot_top prot_checker #(.SAFETY_LOW_CYCLES(SAFETY_LOW_CYCLES)) u_chk (
	.clock(clock), .reset_n(reset_n), .scl_in(scl_in), .sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe),
	.led_enable_input(led_enable_input), .flash_enable_field(flash_enable_field),
	.first_flash_regulator(first_flash_regulator), .second_flash_regulator(second_flash_regulator),
	.safety_timer_reset(safety_timer_reset), .thermistor_guard_enable(thermistor_guard_enable),
	.thermistor_trip_mv(thermistor_trip_mv), .transmit_blank_input(transmit_blank_input),
	.blank_limit_active(blank_limit_active), .blank_current_limit_ma(blank_current_limit_ma),
	.low_battery_enable(low_battery_enable), .low_battery_threshold_mv(low_battery_threshold_mv),
	.low_battery_hysteresis_mv(low_battery_hysteresis_mv), .low_battery_hysteresis_off(low_battery_hysteresis_off)
);

// File: verif/prot_host.sv
`timescale 1ns/1ps
module prot_host #(
	parameter logic [6:0] ADDR = prot_pkg::DEFAULT_SLAVE_ADDR
) (
	// clock
	input wire logic clock,
	// serial bus, open drain
	output logic scl,
	output logic sda_low,
	input wire logic sda
);
	initial begin
		scl = 1'b1;
		sda_low = 1'b0;
	end
	////////////////////////////////////////
	// four clocks per half bit leave room for the slave's one-clock lag
	task automatic half();
		repeat (4) @(negedge clock);
	endtask : half

	task automatic bit_io(input logic b, output logic r);
		sda_low = !b;
		half();
		scl = 1'b1;
		half();
		r = sda;
		scl = 1'b0;
	endtask : bit_io

	task automatic xfer(input logic [7:0] d, input logic mack, output logic [7:0] q, output logic ack);
		logic r;
		for (int i = 7; i >= 0; i--) begin
			bit_io(d[i], r);
			q[i] = r;
		end
		bit_io(mack, r);
		ack = !r;
	endtask : xfer

	// sda is released first so a slave still holding ack cannot mask the start
	task automatic start();
		sda_low = 1'b0;
		half();
		scl = 1'b1;
		half();
		sda_low = 1'b1;
		half();
		scl = 1'b0;
	endtask : start

	task automatic stop();
		sda_low = 1'b1;
		half();
		scl = 1'b1;
		half();
		sda_low = 1'b0;
		half();
	endtask : stop

	task automatic wr(input logic [6:0] sa, input logic [7:0] a, input logic [7:0] d, output logic ack);
		logic [7:0] q;
		logic k1, k2, k3;
		start();
		xfer({sa, 1'b0}, 1'b1, q, k1);
		xfer(a, 1'b1, q, k2);
		xfer(d, 1'b1, q, k3);
		stop();
		ack = k1 & k2 & k3;
	endtask : wr

	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		logic [7:0] q;
		logic k;
		start();
		xfer({ADDR, 1'b0}, 1'b1, q, k);
		xfer(a, 1'b1, q, k);
		start();
		xfer({ADDR, 1'b1}, 1'b1, q, k);
		xfer(8'hff, 1'b1, d, k);
		stop();
	endtask : rd
endmodule : prot_host

// File: verif/protection_config_regs_tb.sv
`timescale 1ns/1ps
module protection_config_regs_tb;
	localparam int LOW = 50;
	logic clock, reset_n, scl, host_low, led, blank, ack;
	logic sda_out, sda_oe, first, second, str, tge, bla, lbe, hoff;
	logic [2:0] field;
	logic [9:0] trip, ilim;
	logic [11:0] lbmv;
	logic [7:0] hys, q;
	int n_mismatch, samples_checked, pulses;
	// host keeps threshold codes at 3 and above
	logic [7:0] lbv [4] = '{8'h8c, 8'h7f, 8'hf9, 8'h0e};
	logic [7:0] hv [4] = '{8'h64, 8'hc8, 8'h00, 8'h00};
	// open-drain wire: pulled high unless a side drives it low
	wire sda = !host_low && (!sda_oe || sda_out);

	prot_top #(.SAFETY_LOW_CYCLES(LOW)) dut (.clock(clock), .reset_n(reset_n), .scl_in(scl), .sda_in(sda),
		.sda_out(sda_out), .sda_oe(sda_oe), .led_enable_input(led), .flash_enable_field(field),
		.first_flash_regulator(first), .second_flash_regulator(second), .safety_timer_reset(str),
		.thermistor_guard_enable(tge), .thermistor_trip_mv(trip), .transmit_blank_input(blank),
		.blank_limit_active(bla), .blank_current_limit_ma(ilim), .low_battery_enable(lbe),
		.low_battery_threshold_mv(lbmv), .low_battery_hysteresis_mv(hys), .low_battery_hysteresis_off(hoff));
	prot_host host (.clock(clock), .scl(scl), .sda_low(host_low), .sda(sda));

	initial begin
		clock = 1'b0;
		forever #20 clock = ~clock;
	end
	always @(posedge clock) if (str === 1'b1) pulses++;
	////////////////////////////////////////
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("ERROR %0t seen %0h expected %0h", $time, seen, exp);
		end
	endtask : check

	task automatic cyc(input int n);
		repeat (n) @(negedge clock);
	endtask : cyc

	task automatic w(input logic [7:0] a, input logic [7:0] d);
		host.wr(prot_pkg::DEFAULT_SLAVE_ADDR, a, d, ack);
		check(ack, 1);
	endtask : w

	task automatic r(input logic [7:0] a, input logic [7:0] exp);
		host.rd(a, q);
		check(q, exp);
	endtask : r

	task automatic report_and_stop();
		if (n_mismatch == 0 && samples_checked > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask : report_and_stop

	// whole run needs well under 1ms
	initial begin
		#3000000;
		n_mismatch++;
		report_and_stop();
	end
	////////////////////////////////////////
	initial begin
		reset_n = 1'b0;
		led = 1'b0;
		blank = 1'b0;
		field = 3'b000;
		repeat (6) @(posedge clock);
		cyc(1);
		reset_n = 1'b1;
		cyc(2);
		r(8'h0b, 8'h00);
		r(8'h0c, 8'hc0);
		r(8'h0d, 8'h00);
		check(trip, 200);
		w(8'h0b, 8'hff);
		r(8'h0b, 8'h8f);
		check(tge, 1);
		check(trip, 550);
		w(8'h0b, 8'h75);
		r(8'h0b, 8'h05);
		check(tge, 0);
		check(trip, 450);
		for (int c = 0; c < 16; c += 5) begin
			w(8'h0c, 8'(c << 2));
			check(ilim, 50 + 50 * c);
		end
		blank = 1'b1;
		cyc(3);
		check(bla, 0);
		// active-low input, hold time per timer code
		for (int c = 0; c < 4; c++) begin
			w(8'h0c, 8'(8'h80 | c));
			cyc(2);
			check(bla, 0);
			blank = 1'b0;
			cyc(2);
			check(bla, 1);
			blank = 1'b1;
			cyc((250 << c) - 20);
			check(bla, 1);
			cyc(40);
			check(bla, 0);
		end
		r(8'h17, 8'h40);
		r(8'h17, 8'h00);
		foreach (lbv[i]) begin
			w(8'h0d, lbv[i]);
			r(8'h0d, lbv[i]);
			check(lbe, lbv[i][7]);
			check(lbmv, 2400 + 100 * ((lbv[i][6:2] > 30) ? 30 : lbv[i][6:2]) / 3);
			check(hys, hv[lbv[i][1:0]]);
			check(hoff, lbv[i][1:0] == 2'b11);
		end
		field = 3'b101;
		led = 1'b1;
		cyc(3);
		check(first, 1);
		check(second, 0);
		pulses = 0;
		led = 1'b0;
		cyc(LOW - 10);
		check(first, 0);
		check(pulses, 0);
		cyc(20);
		check(pulses, 1);
		led = 1'b1;
		w(8'h0b, 8'h80);
		pulses = 0;
		led = 1'b0;
		cyc(4);
		check(pulses, 1);
		field = 3'b110;
		cyc(3);
		check(second, 0);
		led = 1'b1;
		cyc(3);
		check(second, 1);
		check(first, 0);
		field = 3'b011;
		led = 1'b1;
		cyc(3);
		led = 1'b0;
		cyc(4);
		check(pulses, 2);
		check(second, 1);
		w(8'h20, 8'h5a);
		r(8'h20, 8'h00);
		host.wr(7'h55, 8'h0d, 8'hff, ack);
		check(ack, 0);
		r(8'h0d, 8'h0e);
		reset_n = 1'b0;
		cyc(2);
		reset_n = 1'b1;
		cyc(2);
		r(8'h0c, 8'hc0);
		r(8'h0b, 8'h00);
		report_and_stop();
	end
endmodule : protection_config_regs_tb
